// ---- acc_clk_div.v ----
`timescale 1ns/10ps
`include "acc_defs.vh"
module acc_clk_div
(
    clk,
    reset_n,
    run,
    div_code,
    tick
);
    input  wire       clk;
    input  wire       reset_n;
    input  wire       run;
    input  wire [2:0] div_code;
    output reg        tick;

    reg  [4:0] cnt_r;
    wire [4:0] limit;

    // Divide by 1,2,4,8,16,32; codes above 101 clamp to 32
    assign limit = (div_code > `ACC_TEMP_DIV) ? 5'h1F :
                   (5'h01 << div_code) - 5'h01;

    always @(posedge clk)
    begin
        if (!reset_n || !run)
        begin
            cnt_r <= 5'h00;
            tick  <= 1'b0;
        end
        else if (cnt_r >= limit)
        begin
            cnt_r <= 5'h00;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 5'h01;
            tick  <= 1'b0;
        end
    end
endmodule // acc_clk_div

// ---- acc_core_model.sv ----
`timescale 1ns/10ps
module acc_core_model
(
    input  wire        clk,
    input  wire        track_hold,
    input  wire        core_power,
    input  wire [4:0]  mux_pos,
    input  wire [11:0] level,
    output reg  [11:0] core_code
);
    reg        th_r;
    reg [11:0] held_r;
    initial core_code = 12'h000;
    always @(posedge clk)
    begin
        th_r <= track_hold;
        if (th_r && !track_hold)
            held_r <= level + mux_pos;
        // Churns while tracking or unpowered so a stale code is never taken for a result
        core_code <= (core_power && !track_hold) ? held_r : ~core_code;
    end
endmodule // acc_core_model

// ---- acc_defs.vh ----
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_CTRL_RESET      16'h0600
`define ACC_CLKDIV_LSB      10
`define ACC_CLKDIV_MSB      12
`define ACC_ACQ_LSB         8
`define ACC_ACQ_MSB         9
`define ACC_START_EN_BIT    7
`define ACC_BUSY_EN_BIT     6
`define ACC_POWER_BIT       5
`define ACC_MODE_LSB        3
`define ACC_MODE_MSB        4
`define ACC_TYPE_LSB        0
`define ACC_TYPE_MSB        2
`define ACC_MODE_SINGLE     2'h0
`define ACC_MODE_DIFF       2'h1
`define ACC_MODE_PSEUDO     2'h2
`define ACC_TYPE_EXT        3'h0
`define ACC_TYPE_TMR0       3'h1
`define ACC_TYPE_TMR1       3'h2
`define ACC_TYPE_SINGLE     3'h3
`define ACC_TYPE_CONT       3'h4
`define ACC_TYPE_ARRAY      3'h5
`define ACC_EXTRA_CLKS      5'h13
`define ACC_TEMP_ACQ        2'h3
`define ACC_TEMP_DIV        3'h5
`define ACC_RES_LSB         16
`define ACC_RES_MSB         27
`define ACC_REG_COUNT       8
`endif

// ---- acc_formatter.v ----
`timescale 1ns/10ps
`include "acc_defs.vh"
module acc_formatter
(
    raw_code,
    diff_mode,
    data_word
);
    input  wire [11:0] raw_code;
    input  wire        diff_mode;
    output wire [31:0] data_word;

    wire sign;

    // Straight binary has no sign; two's complement sign is code MSB
    assign sign = diff_mode & raw_code[11];
    // Signed result shifted 16 right is read as plain signed integer
    assign data_word = {{4{sign}}, raw_code, 16'h0000};
endmodule // acc_formatter

// ---- acc_sva.sv ----
`timescale 1ns/10ps
`include "acc_defs.vh"
module acc_sva
#(
    parameter       CHAN_W    = 5,
    parameter [4:0] TEMP_CHAN = 5'h10
)
(
    input wire              clk,
    input wire              reset_n,
    input wire [15:0]       converter_control,
    input wire [CHAN_W-1:0] positive_channel_select,
    input wire [CHAN_W-1:0] negative_channel_select,
    input wire [31:0]       conversion_result,
    input wire [CHAN_W-1:0] mux_pos,
    input wire [CHAN_W-1:0] mux_neg,
    input wire              track_hold,
    input wire              core_clk_tick,
    input wire              busy,
    input wire              busy_pin,
    input wire              done_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_LOW_ZERO: assert property ($changed(conversion_result) |->
        conversion_result[15:0] == 16'h0000) else $error("low half set");
    AST_SIGN: assert property ($changed(conversion_result)
        |-> conversion_result[31:28] == ((converter_control[4:3] ==
        `ACC_MODE_DIFF) ? {4{conversion_result[27]}} : 4'h0))
        else $error("sign bits wrong");
    AST_AT_END: assert property ($changed(conversion_result) |->
        $fell(busy)) else $error("result moved mid conversion");
    AST_DONE: assert property ($fell(busy) |-> done_flag)
        else $error("no done flag");
    AST_BUSY_PIN: assert property (busy_pin ==
        $past(busy && converter_control[6])) else $error("busy pin");
    AST_POWER: assert property ($rose(busy) |->
        $past(converter_control[5])) else $error("start while off");
    AST_TRACK: assert property (track_hold |-> busy)
        else $error("tracking while idle");
    AST_ACQ: assert property ($rose(busy) |-> track_hold)
        else $error("no acquisition");
    AST_RESV: assert property (converter_control[15:14] == 2'h0)
        else $error("reserved bits set");
    AST_TEMP: assert property (core_clk_tick && busy &&
        mux_pos == TEMP_CHAN |=> !core_clk_tick [*8])
        else $error("temp divider");
    // Selects may be rewritten mid conversion, so check at capture only
    AST_MUX: assert property ($rose(busy) |->
        mux_pos == $past(positive_channel_select)
        && mux_neg == $past(negative_channel_select)) else $error("mux");
endmodule // acc_sva
bind acc_top acc_sva #(.CHAN_W(CHAN_W), .TEMP_CHAN(TEMP_CHAN)) u_sva
(.clk(clk), .reset_n(reset_n), .converter_control(converter_control),
 .positive_channel_select(positive_channel_select),
 .negative_channel_select(negative_channel_select),
 .conversion_result(conversion_result), .mux_pos(mux_pos),
 .mux_neg(mux_neg), .track_hold(track_hold),
 .core_clk_tick(core_clk_tick), .busy(busy), .busy_pin(busy_pin),
 .done_flag(done_flag));

// ---- acc_top.v ----
`timescale 1ns/10ps
`include "acc_defs.vh"
module acc_top
#(
    parameter CHAN_W = 5,
    parameter [4:0] TEMP_CHAN = 5'h10
)
(
    clk,
    reset_n,
    ctrl_wr,
    ctrl_wdata,
    pos_sel_wr,
    pos_sel_wdata,
    neg_sel_wr,
    neg_sel_wdata,
    result_rd,
    conv_start_pin,
    logic_array_trig,
    first_timer_ovf,
    second_timer_ovf,
    core_code,
    converter_control,
    positive_channel_select,
    negative_channel_select,
    conversion_result,
    mux_pos,
    mux_neg,
    mux_mode,
    core_power,
    track_hold,
    core_clk_tick,
    busy,
    busy_pin,
    done_flag
);
    input  wire              clk;
    input  wire              reset_n;
    input  wire              ctrl_wr;
    input  wire [15:0]       ctrl_wdata;
    input  wire              pos_sel_wr;
    input  wire [CHAN_W-1:0] pos_sel_wdata;
    input  wire              neg_sel_wr;
    input  wire [CHAN_W-1:0] neg_sel_wdata;
    input  wire              result_rd;
    input  wire              conv_start_pin;
    input  wire              logic_array_trig;
    input  wire              first_timer_ovf;
    input  wire              second_timer_ovf;
    input  wire [11:0]       core_code;
    output reg  [15:0]       converter_control;
    output reg  [CHAN_W-1:0] positive_channel_select;
    output reg  [CHAN_W-1:0] negative_channel_select;
    output reg  [31:0]       conversion_result;
    output reg  [CHAN_W-1:0] mux_pos;
    output reg  [CHAN_W-1:0] mux_neg;
    output reg  [1:0]        mux_mode;
    output reg               core_power;
    output reg               track_hold;
    output reg               core_clk_tick;
    output reg               busy;
    output reg               busy_pin;
    output reg               done_flag;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ACQ  = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Acquisition code to clock count minus one
    function [4:0] acq_last;
        input [1:0] code;
        begin
            acq_last = (5'h02 << code) - 5'h01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register state

    reg  [2:0]  state_r;
    reg  [4:0]  cnt_r;
    reg         temp_hold_r;
    reg         pin_d_r;
    reg         cont_r;
    wire [1:0]  acq_code;
    wire [2:0]  div_code;
    wire [2:0]  conv_type;
    wire        temp_sel;
    wire        tick;
    wire        trig;
    wire        sw_go;
    wire [31:0] fmt_word;
    wire        power_on;

    assign conv_type = converter_control[`ACC_TYPE_MSB:`ACC_TYPE_LSB];
    assign power_on  = converter_control[`ACC_POWER_BIT];
    // Temperature input is one more channel code on the positive mux
    assign temp_sel  = (positive_channel_select == TEMP_CHAN);
    // Forced timing holds until that temperature result has been read
    assign acq_code  = (temp_sel || temp_hold_r) ? `ACC_TEMP_ACQ :
                       converter_control[`ACC_ACQ_MSB:`ACC_ACQ_LSB];
    assign div_code  = (temp_sel || temp_hold_r) ? `ACC_TEMP_DIV :
                       converter_control[`ACC_CLKDIV_MSB:`ACC_CLKDIV_LSB];

    // Edge trigger on start pin, pulse inputs from array and timers
    assign trig = (conv_type == `ACC_TYPE_EXT
                   && conv_start_pin && !pin_d_r)
                || (conv_type == `ACC_TYPE_TMR0 && first_timer_ovf)
                || (conv_type == `ACC_TYPE_TMR1 && second_timer_ovf)
                || (conv_type == `ACC_TYPE_ARRAY
                    && logic_array_trig);
    assign sw_go = ctrl_wr && ctrl_wdata[`ACC_START_EN_BIT]
                && (ctrl_wdata[`ACC_TYPE_MSB:`ACC_TYPE_LSB] == `ACC_TYPE_SINGLE
                 || ctrl_wdata[`ACC_TYPE_MSB:`ACC_TYPE_LSB] == `ACC_TYPE_CONT);

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    acc_clk_div u_div
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (state_r != ST_IDLE),
        .div_code (div_code),
        .tick     (tick)
    );

    acc_formatter u_fmt
    (
        .raw_code  (core_code),
        .diff_mode (mux_mode == `ACC_MODE_DIFF),
        .data_word (fmt_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            converter_control       <= `ACC_CTRL_RESET;
            positive_channel_select <= {CHAN_W{1'b0}};
            negative_channel_select <= {CHAN_W{1'b0}};
            pin_d_r                 <= 1'b0;
        end
        else
        begin
            pin_d_r <= conv_start_pin;
            if (ctrl_wr)
                converter_control <= {2'h0, ctrl_wdata[13:0]};
            if (pos_sel_wr)
                positive_channel_select <= pos_sel_wdata;
            if (neg_sel_wr)
                negative_channel_select <= neg_sel_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_r           <= ST_IDLE;
            cnt_r             <= 5'h00;
            cont_r            <= 1'b0;
            temp_hold_r       <= 1'b0;
            conversion_result <= 32'h00000000;
            mux_pos           <= {CHAN_W{1'b0}};
            mux_neg           <= {CHAN_W{1'b0}};
            mux_mode          <= `ACC_MODE_SINGLE;
            core_power        <= 1'b0;
            track_hold        <= 1'b0;
            core_clk_tick     <= 1'b0;
            busy              <= 1'b0;
            busy_pin          <= 1'b0;
            done_flag         <= 1'b0;
        end
        else
        begin
            // Power-up settling is left to software, no wait here
            core_power    <= power_on;
            core_clk_tick <= tick;
            busy_pin      <= busy && converter_control[`ACC_BUSY_EN_BIT];
            // Read of the result clears the flag; a new completion wins
            if (result_rd)
            begin
                done_flag   <= 1'b0;
                temp_hold_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE:
                begin
                    if (power_on && (sw_go || cont_r ||
                        (converter_control[`ACC_START_EN_BIT] && trig)))
                    begin
                        state_r    <= ST_ACQ;
                        cnt_r      <= 5'h00;
                        mux_pos    <= positive_channel_select;
                        mux_neg    <= negative_channel_select;
                        // Reserved mode code treated as single-ended
                        mux_mode   <= (converter_control[`ACC_MODE_MSB:
                                       `ACC_MODE_LSB] == 2'h3) ?
                                      `ACC_MODE_SINGLE :
                                      converter_control[`ACC_MODE_MSB:
                                      `ACC_MODE_LSB];
                        track_hold <= 1'b1;
                        busy       <= 1'b1;
                        if (sw_go)
                            cont_r <= (ctrl_wdata[`ACC_TYPE_MSB:
                                      `ACC_TYPE_LSB] == `ACC_TYPE_CONT);
                        if (temp_sel)
                            temp_hold_r <= 1'b1;
                    end
                end
                ST_ACQ:
                begin
                    if (tick)
                    begin
                        if (cnt_r >= acq_last(acq_code))
                        begin
                            state_r    <= ST_CONV;
                            cnt_r      <= 5'h00;
                            track_hold <= 1'b0;
                        end
                        else
                            cnt_r <= cnt_r + 5'h01;
                    end
                end
                ST_CONV:
                begin
                    if (tick)
                    begin
                        if (cnt_r >= `ACC_EXTRA_CLKS - 5'h01)
                        begin
                            state_r           <= ST_IDLE;
                            busy              <= 1'b0;
                            conversion_result <= fmt_word;
                            done_flag         <= 1'b1;
                        end
                        else
                            cnt_r <= cnt_r + 5'h01;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
            // Continuous mode stops on a write selecting another type
            if (ctrl_wr && ctrl_wdata[`ACC_TYPE_MSB:`ACC_TYPE_LSB]
                != `ACC_TYPE_CONT)
                cont_r <= 1'b0;
            if (!power_on)
                cont_r <= 1'b0;
        end
    end
endmodule // acc_top

// ---- tb_adc_conversion_control.sv ----
`timescale 1ns/10ps
`include "acc_defs.vh"
module tb_adc_conversion_control;
    reg         clk, reset_n, ctrl_wr, psw, nsw, result_rd;
    reg         pin, arr, t0, t1;
    reg  [15:0] ctrl_wdata;
    reg  [4:0]  pw, nw;
    reg  [11:0] level;
    wire [11:0] core_code;
    wire [15:0] ctl;
    wire [4:0]  pq, nq, mp, mn;
    wire [31:0] res;
    wire [1:0]  mm;
    wire        pwr, th, tick, busy, bpin, done;
    integer     error_cnt, checked, i, cyc, e, dv;
    reg  [2:0]  d;
    reg  [1:0]  a, m;
    acc_top dut (.clk(clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .pos_sel_wr(psw), .pos_sel_wdata(pw),
        .neg_sel_wr(nsw), .neg_sel_wdata(nw), .result_rd(result_rd),
        .conv_start_pin(pin), .logic_array_trig(arr),
        .first_timer_ovf(t0), .second_timer_ovf(t1), .core_code(core_code),
        .converter_control(ctl), .positive_channel_select(pq),
        .negative_channel_select(nq), .conversion_result(res),
        .mux_pos(mp), .mux_neg(mn), .mux_mode(mm), .core_power(pwr),
        .track_hold(th), .core_clk_tick(tick), .busy(busy),
        .busy_pin(bpin), .done_flag(done));
    acc_core_model u_core (.clk(clk), .track_hold(th), .core_power(pwr),
        .mux_pos(mp), .level(level), .core_code(core_code));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task results;
    begin
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task wctl(input [15:0] v);
    begin
        @(negedge clk) ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(negedge clk) ctrl_wr = 1'b0;
    end
    endtask
    task wsel(input [4:0] p, input [4:0] n);
    begin
        @(negedge clk) {psw, nsw, pw, nw} = {2'b11, p, n};
        @(negedge clk) {psw, nsw} = 2'b00;
    end
    endtask
    task rd;
    begin
        @(negedge clk) result_rd = 1'b1;
        @(negedge clk) result_rd = 1'b0;
    end
    endtask
    // Arms with start clear first, so only the chosen source can start it
    task conv(input [15:0] c);
    begin
        wctl(c & 16'hFF7F);
        wctl(c);
        @(negedge clk) {pin, t0, t1, arr} = {c[2:0] == 3'h0, c[2:0] == 3'h1,
            c[2:0] == 3'h2, c[2:0] == 3'h5};
        @(negedge clk) {pin, t0, t1, arr} = 4'h0;
        for (cyc = 0; cyc < 8 && busy !== 1'b1; cyc = cyc + 1)
            @(negedge clk);
        chk("busy", busy, 1'b1);
        for (cyc = 0; cyc < 3000 && busy === 1'b1; cyc = cyc + 1)
            @(negedge clk);
    end
    endtask
    function [31:0] exp_word(input [11:0] c, input [1:0] md);
        exp_word = {(md == `ACC_MODE_DIFF) ? {4{c[11]}} : 4'h0, c, 16'h0000};
    endfunction
    task chk_time(input [2:0] dc, input [1:0] ac);
    begin
        dv = 1 << ((dc > 3'h5) ? 3'h5 : dc);
        e = ((2 << ac) + `ACC_EXTRA_CLKS) * dv;
        chk("cycles", cyc >= e - dv && cyc <= e + dv + 4, 1);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #(50 * 60000);
        error_cnt = error_cnt + 1;
        results;
    end
    initial
    begin
        {reset_n, ctrl_wr, psw, nsw, result_rd, pin, arr, t0, t1} = 9'h000;
        {ctrl_wdata, pw, nw, level, error_cnt, checked} = 0;
        void'($urandom(32'h82F11426));
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        chk("ctrl", ctl, 16'h0600);
        chk("result", res, 32'h0);
        chk("idle", {pq, nq, mp, mn, mm, done, pwr, th, tick, busy, bpin},
            28'h0);
        $display("test reset ended");
        wctl(16'hC683);
        repeat (4) @(negedge clk);
        chk("ctrl", ctl, 16'h0683);
        chk("busy off", busy, 1'b0);
        wctl(16'h0620);
        repeat (100) @(negedge clk);
        $display("test refuse ended");
        for (i = 0; i < 12; i = i + 1)
        begin
            d = (i == 0) ? 3'h0 : (i == 1) ? 3'h5 : $urandom % 8;
            a = (i < 2) ? i * 3 : $urandom % 4;
            m = $urandom % 4;
            level = $urandom;
            wsel($urandom % 16, $urandom % 16);
            conv({3'h0, d, a, 3'h7, m, 3'h3});
            chk_time(d, a);
            chk("word", res, exp_word(level + pw, m));
            chk("mode", {pwr, mm}, {1'b1, (m == 2'h3) ? 2'h0 : m});
            rd;
            chk("done", done, 1'b0);
        end
        $display("test random ended");
        for (i = 0; i < 4; i = i + 1)
        begin
            conv({8'h06, 5'h15, (i == 3) ? 3'h5 : i[2:0]});
            chk("trig done", done, 1'b1);
            rd;
        end
        $display("test triggers ended");
        wsel(5'h10, 5'h00);
        conv(16'h07A3);
        chk_time(3'h5, 2'h3);
        chk("temp", res, exp_word(level + 5'h10, 2'h0));
        rd;
        wsel(5'h03, 5'h00);
        conv(16'h00A3);
        chk_time(3'h0, 2'h0);
        $display("test temp ended");
        conv(16'h00A4);
        for (cyc = 0; cyc < 6 && busy !== 1'b1; cyc = cyc + 1)
            @(negedge clk);
        chk("restart", busy, 1'b1);
        wctl(16'h0023);
        for (cyc = 0; cyc < 200 && busy === 1'b1; cyc = cyc + 1)
            @(negedge clk);
        repeat (3) @(negedge clk);
        chk("stopped", busy, 1'b0);
        $display("test continuous ended");
        results;
    end
endmodule // tb_adc_conversion_control
